/* core/cms_ctl.sv */
// Control mode select, hardware strap capture, clock edge select and loss-of-signal output
`timescale 1ns/1ps
`default_nettype none
module cms_ctl (
  input  wire logic              mclk,             // 25 MHz master clock
  input  wire logic              rst_n,            // Async reset, active low
  input  wire logic [1:0]        modeSel,          // Control interface select strap
  input  wire logic              sigLost,          // Raw loss detection from receiver
  input  wire logic              rxClockEdgeSel,   // Receive clock edge select pin
  input  wire logic              shiftEdgeSel,     // Shift edge select pin
  input  wire cms_pkg::cms_hwcfg_t hwPins,         // Hardware configuration pins
  input  wire logic              rxBitIn,          // Receive data from recovery
  input  wire logic              rxClkRise,        // Recovered clock rising event
  input  wire logic              rxClkFall,        // Recovered clock falling event
  input  wire logic              serialBitIn,      // Next serial out bit from port
  input  wire logic              shiftClkRise,     // Shift clock rising event
  input  wire logic              shiftClkFall,     // Shift clock falling event
  output var  cms_pkg::cms_mode_t  ctlMode,        // Decoded control mode
  output var  cms_pkg::cms_ifsel_t ifSel,          // Interface enables
  output var  cms_pkg::cms_hwcfg_t hwCfg,          // Captured hardware config
  output logic                   lossOfSignal,     // Active high loss indicator
  output logic                   rxFallEdge,       // Active receive edge is falling
  output logic                   rxData,           // Receive data launched
  output logic                   serialOut,        // Serial data out
  output logic                   serialOutEn       // Serial out enable
);

  // Synchroniser stages for pins
  logic [1:0] modeS1_q, modeS2_q;
  logic       losS1_q, losS2_q;
  logic       rceS1_q, rceS2_q;
  logic       seS1_q, seS2_q;
  cms_pkg::cms_hwcfg_t hwS1_q, hwS2_q;

  // Two-flop sync; first stage read only by second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeS1_q <= cms_pkg::MODE_HW_CODE;
      modeS2_q <= cms_pkg::MODE_HW_CODE;
      losS1_q  <= cms_pkg::BIT_RST;
      losS2_q  <= cms_pkg::BIT_RST;
      rceS1_q  <= cms_pkg::BIT_RST;
      rceS2_q  <= cms_pkg::BIT_RST;
      seS1_q   <= cms_pkg::BIT_RST;
      seS2_q   <= cms_pkg::BIT_RST;
      hwS1_q   <= cms_pkg::HWCFG_RST;
      hwS2_q   <= cms_pkg::HWCFG_RST;
    end else begin
      modeS1_q <= modeSel;
      modeS2_q <= modeS1_q;
      losS1_q  <= sigLost;
      losS2_q  <= losS1_q;
      rceS1_q  <= rxClockEdgeSel;
      rceS2_q  <= rceS1_q;
      seS1_q   <= shiftEdgeSel;
      seS2_q   <= seS1_q;
      hwS1_q   <= hwPins;
      hwS2_q   <= hwS1_q;
    end
  end

  // Mode decode function, used for state and checks
  function automatic cms_pkg::cms_mode_t decodeMode(input logic [1:0] code);
    cms_pkg::cms_mode_t m;
    m = cms_pkg::CMS_HW;
    if (code == cms_pkg::MODE_SER_CODE) begin
      m = cms_pkg::CMS_SERIAL;
    end else if (code == cms_pkg::MODE_ASRW_CODE) begin
      m = cms_pkg::CMS_MUX_AS;
    end else if (code == cms_pkg::MODE_ALE_CODE) begin
      m = cms_pkg::CMS_MUX_ALE;
    end
    return m;
  endfunction

  // Registered state
  cms_pkg::cms_mode_t  mode_q, mode_d;
  cms_pkg::cms_hwcfg_t cfg_q, cfg_d;
  logic los_q, los_d;
  logic fall_q, fall_d;
  logic rxd_q, rxd_d;
  logic sdo_q, sdo_d;
  logic sdoEn_q, sdoEn_d;

  // Next-state computation
  always_comb begin
    // [R3] mode decode
    mode_d = decodeMode(modeS2_q);
    // [R1] [R2] loss follows detector
    los_d = losS2_q;
    cfg_d = cfg_q;
    fall_d = 1'b0;
    // Gate on the freshly synchronised mode, not mode_q: the pins and the strap
    // share the same sync depth, so a mode change never lets new pins leak into hwCfg
    // and the edge choice moves in the same cycle as ctlMode
    case (mode_d)
      cms_pkg::CMS_HW: begin
        // [R7] hardware pins apply
        cfg_d = hwS2_q;
        // [R8] [R9] [R10] edge from pin
        fall_d = rceS2_q;
      end
      // Software modes ignore edge pin, rising edge used
      default: begin
        cfg_d = cfg_q;
        fall_d = 1'b0;
      end
    endcase
    // [R12] launch on active receive edge
    rxd_d = rxd_q;
    if ((fall_q && rxClkFall) || (!fall_q && rxClkRise)) begin
      rxd_d = rxBitIn;
    end
    // [R5] [R13] shift out on chosen edge
    sdo_d = sdo_q;
    if ((seS2_q && shiftClkFall) || (!seS2_q && shiftClkRise)) begin
      sdo_d = serialBitIn;
    end
    // [R4] serial pin group active in serial mode
    sdoEn_d = (mode_q == cms_pkg::CMS_SERIAL);
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= cms_pkg::CMS_HW;
      cfg_q   <= cms_pkg::HWCFG_RST;
      los_q   <= cms_pkg::BIT_RST;
      fall_q  <= cms_pkg::BIT_RST;
      rxd_q   <= cms_pkg::BIT_RST;
      sdo_q   <= cms_pkg::BIT_RST;
      sdoEn_q <= cms_pkg::BIT_RST;
    end else begin
      mode_q  <= mode_d;
      cfg_q   <= cfg_d;
      los_q   <= los_d;
      fall_q  <= fall_d;
      rxd_q   <= rxd_d;
      sdo_q   <= sdo_d;
      sdoEn_q <= sdoEn_d;
    end
  end

  // Output drive; [R4] [R6] interface enables from mode
  always_comb begin
    ifSel.serialEn    = (mode_q == cms_pkg::CMS_SERIAL);
    ifSel.parallelEn  = (mode_q == cms_pkg::CMS_MUX_AS) || (mode_q == cms_pkg::CMS_MUX_ALE);
    ifSel.muxAleStyle = (mode_q == cms_pkg::CMS_MUX_ALE);
    ifSel.hwEn        = (mode_q == cms_pkg::CMS_HW);
  end

  assign ctlMode      = mode_q;
  assign hwCfg        = cfg_q;
  assign lossOfSignal = los_q;
  assign rxFallEdge   = fall_q;
  assign rxData       = rxd_q;
  assign serialOut    = sdo_q;
  assign serialOutEn  = sdoEn_q;

  // Loss indicator follows synchronised detector
  // [R1] loss raised on detection
  a_los_follow: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    $rose(losS2_q) |=> lossOfSignal)
    else $error("loss output did not rise");
  // [R2] loss released unaided
  a_los_clear: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    $fell(losS2_q) |=> !lossOfSignal)
    else $error("loss output did not clear");
  // [R1] loss level one cycle behind
  a_los_level: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    lossOfSignal == $past(losS2_q))
    else $error("loss output does not track detector");
  // [R3] strap decode
  a_mode_decode: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
    ##1 (ctlMode == decodeMode($past(modeS2_q))))
    else $error("mode decode mismatch");
  // [R9] low pin gives rising edge
  a_edge_rise: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
    !rceS2_q |=> !rxFallEdge)
    else $error("rising edge not selected");
  // [R10] high pin gives falling edge
  a_edge_fall: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    rceS2_q |=> (rxFallEdge == (ctlMode == cms_pkg::CMS_HW)))
    else $error("falling edge not selected");
  // [R8] pin ignored in software modes
  a_edge_soft: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    (ctlMode != cms_pkg::CMS_HW) |-> !rxFallEdge)
    else $error("edge pin honoured outside hardware mode");
  // [R12] launch on falling edge
  a_rx_launch: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    (rxFallEdge && rxClkFall) |=> (rxData == $past(rxBitIn)))
    else $error("receive data not launched");
  // [R12] launch on rising edge
  a_rx_rise: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    (!rxFallEdge && rxClkRise) |=> (rxData == $past(rxBitIn)))
    else $error("receive data not launched on rising edge");
  // [R13] shift out on falling edge
  a_sdo_edge: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    (seS2_q && shiftClkFall) |=> (serialOut == $past(serialBitIn)))
    else $error("serial out not shifted on falling edge");
  // [R13] shift out on rising edge
  a_sdo_rise: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
    (!seS2_q && shiftClkRise) |=> (serialOut == $past(serialBitIn)))
    else $error("serial out not shifted on rising edge");
  // [R4] serial output enabled in serial mode
  a_ser_group: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    ifSel.serialEn |=> serialOutEn)
    else $error("serial output not enabled");
  // [R4] serial output quiet elsewhere
  a_ser_off: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    !ifSel.serialEn |=> !serialOutEn)
    else $error("serial output enabled outside serial mode");
  // [R7] pins captured in hardware mode
  a_hw_cfg: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    (modeS2_q == cms_pkg::MODE_HW_CODE) |=> (hwCfg == $past(hwS2_q)))
    else $error("hardware config not captured");
  // [R7] pins frozen in software modes
  a_cfg_hold: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    (modeS2_q != cms_pkg::MODE_HW_CODE) |=> $stable(hwCfg))
    else $error("hardware config changed outside hardware mode");

endmodule : cms_ctl
`default_nettype wire

/* core/cms_pkg.sv */
// Package with constants and types for the control mode select and loss-of-signal block
// Summary of operation
// [R1] Drive loss-of-signal high when signal lost
// [R2] Release loss-of-signal when valid signal returns
// [R3] Decode two-bit select into four control modes
// [R4] Serial port uses select, clock, edge, data, interrupt
// [R5] Shift edge select picks shift clock edge
// [R6] Parallel port uses select, bus, strobes, interrupt
// [R7] Hardware mode takes configuration from strap pins
// [R8] Receive edge select honoured in hardware mode only
// [R9] Low select means rising receive edge
// [R10] High select means falling receive edge
// [R11] Software modes tie receive edge select low
// [R12] Receive data launched on selected active edge
// [R13] Serial out on falling edge when select high
// [R14] Control select is a static strap
package cms_pkg;

  // Control interface mode codes
  localparam logic [1:0] MODE_HW_CODE   = 2'h0;
  localparam logic [1:0] MODE_SER_CODE  = 2'h1;
  localparam logic [1:0] MODE_ASRW_CODE = 2'h2;
  localparam logic [1:0] MODE_ALE_CODE  = 2'h3;

  // Decoded control interface mode
  typedef enum logic [1:0] {
    CMS_HW,
    CMS_SERIAL,
    CMS_MUX_AS,
    CMS_MUX_ALE
  } cms_mode_t;

  // Hardware configuration pin group
  typedef struct packed {
    logic [3:0] pulseTemplateSel;
    logic       txHizCtl;
    logic [1:0] loopbackSel;
    logic [1:0] patternSel;
    logic [1:0] jitterAttSel;
    logic       monitorGainSel;
    logic       termSel;
    logic [1:0] railCodingSel;
  } cms_hwcfg_t;

  // Decoded interface enables
  typedef struct packed {
    logic serialEn;
    logic parallelEn;
    logic muxAleStyle;
    logic hwEn;
  } cms_ifsel_t;

  // Reset values
  localparam cms_hwcfg_t HWCFG_RST = '0;
  localparam logic       BIT_RST   = 1'b0;

endpackage : cms_pkg

/* tb/cms_far_end.sv */
// Far-side model: recovered and shift clock edge events
`timescale 1ns/1ps
`default_nettype none
module cms_far_end (
  input  wire logic mclk,         // Master clock
  input  wire logic rst_n,        // Async reset, active low
  output logic      rxClkRise,    // Recovered clock rising event
  output logic      rxClkFall,    // Recovered clock falling event
  output logic      shiftClkRise, // Shift clock rising event
  output logic      shiftClkFall  // Shift clock falling event
);
  logic [1:0] phase_q; // Quarter phase of both clocks
  // Free-running phase, edges one cycle apart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) phase_q <= 2'h0;
    else phase_q <= phase_q + 2'h1;
  end
  assign rxClkRise = (phase_q == 2'h0);
  assign rxClkFall = (phase_q == 2'h2);
  assign shiftClkRise = (phase_q == 2'h1);
  assign shiftClkFall = (phase_q == 2'h3);
endmodule // cms_far_end
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for control mode select and loss-of-signal
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0, rst_n = 1'b0, sigLost = 1'b0;
  logic [1:0] modeSel = 2'h0;
  logic rxEdge = 1'b0, shEdge = 1'b0, rxBit = 1'b0, serBit = 1'b0;
  cms_pkg::cms_hwcfg_t pins = '0, expCfg = '0, hwCfg;
  cms_pkg::cms_mode_t ctlMode;
  cms_pkg::cms_ifsel_t ifSel;
  wire logic rxR, rxF, shR, shF;
  logic los, fallEdge, rxData, serOut, serOutEn, expRx, expSer;
  logic [31:0] seed = 32'h436f;
  int failures = 0, check_count = 0;
  // Free clock, 40 ns period
  always #20 mclk = ~mclk;
  cms_ctl i_dut (.mclk(mclk), .rst_n(rst_n), .modeSel(modeSel), .sigLost(sigLost),
    .rxClockEdgeSel(rxEdge), .shiftEdgeSel(shEdge), .hwPins(pins), .rxBitIn(rxBit),
    .rxClkRise(rxR), .rxClkFall(rxF), .serialBitIn(serBit), .shiftClkRise(shR),
    .shiftClkFall(shF), .ctlMode(ctlMode), .ifSel(ifSel), .hwCfg(hwCfg),
    .lossOfSignal(los), .rxFallEdge(fallEdge), .rxData(rxData), .serialOut(serOut),
    .serialOutEn(serOutEn));
  cms_far_end i_far (.mclk(mclk), .rst_n(rst_n), .rxClkRise(rxR), .rxClkFall(rxF),
    .shiftClkRise(shR), .shiftClkFall(shF));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Random data each cycle; expected launch on the selected edge
  always @(posedge mclk) begin
    seed <= xs(seed);
    rxBit <= seed[0];
    serBit <= seed[1];
    if (((modeSel == 2'h0) & rxEdge) ? rxF : rxR) expRx <= rxBit;
    if (shEdge ? shF : shR) expSer <= serBit;
  end
  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Strap changes only under reset; edge pin grounded outside hardware mode
  task automatic run_mode(input logic [1:0] m, input logic e);
    @(posedge mclk);
    rst_n <= 1'b0;
    modeSel <= m;
    pins <= cms_pkg::cms_hwcfg_t'(seed[$bits(cms_pkg::cms_hwcfg_t)-1:0]);
    rxEdge <= (m == 2'h0) ? e : 1'b0;
    shEdge <= (m == 2'h1) ? e : seed[21];
    @(negedge mclk);
    chk("rstsel", 17'h1, 17'(ifSel));
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    expCfg = (m == 2'h0) ? pins : cms_pkg::HWCFG_RST;
    chk("mode", 17'(m), 17'(ctlMode));
    chk("ifsel", {13'h0, m == 2'h1, m[1], m == 2'h3, m == 2'h0}, 17'(ifSel));
    chk("hwcfg", 17'(expCfg), 17'(hwCfg));
    chk("rxedge", 17'((m == 2'h0) & e), 17'(fallEdge));
    chk("sdoen", 17'(m == 2'h1), 17'(serOutEn));
    repeat (16) begin
      @(negedge mclk);
      chk("rxdata", 17'(expRx), 17'(rxData));
      if (m == 2'h1) chk("sdo", 17'(expSer), 17'(serOut));
    end
    $display("Test mode %0d edge %0d done", m, e);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk("rstsel", 17'h1, 17'(ifSel));
    @(posedge mclk);
    rst_n <= 1'b1;
    run_mode(2'h0, 1'b1);
    run_mode(2'h1, 1'b0);
    run_mode(2'h1, 1'b1);
    run_mode(2'h2, 1'b1);
    run_mode(2'h3, 1'b0);
    run_mode(2'h0, 1'b0);
    // Loss raised, then dropped with no other action
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk);
      sigLost <= v[0];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("losold", 17'(!v[0]), 17'(los));
      @(negedge mclk);
      chk("los", 17'(v[0]), 17'(los));
    end
    $display("Test loss of signal done");
    report_and_stop();
  end
  // Watchdog well past the expected run length
  initial begin
    #40000;
    failures++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
